// [csbi_agent.sv]
module csbi_agent (
    // Clock, reset and enable
    input  wire logic                       core_clk_i,
    input  wire logic                       srst_i,
    input  wire logic                       clk_en_i,
    // User side
    input  wire logic                       soft_rst_req_i,
    input  wire logic [csbi_pkg::BUS_W-1:0] rd_data_i,
    output logic                            wr_valid_o,
    output logic [csbi_pkg::BUS_W-1:0]      wr_addr_o,
    output logic [csbi_pkg::BUS_W-1:0]      wr_data_o,
    output logic                            rd_req_o,
    // Link to device
    csbi_if.agt                             bus
);
    import csbi_pkg::*;

    //------------------------------------------------------------------
    // Soft reset stretcher
    //------------------------------------------------------------------
    logic [4:0] rst_cnt;   // Cycles of reset still to hold.

    // A one-cycle request becomes a constant level of the least length.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rst_cnt     <= 5'h00;
            bus.rst_req <= 1'b0;
        end else if (clk_en_i) begin
            rst_cnt     <= soft_rst_req_i ? SOFT_RST_CNT :
                           (rst_cnt != 5'h00) ? rst_cnt - 5'h01 : 5'h00;
            bus.rst_req <= soft_rst_req_i || (rst_cnt > 5'h01);
        end
    end

    //------------------------------------------------------------------
    // Request decode and read return
    //------------------------------------------------------------------
    logic [CNT_W-1:0] rd_left;   // Read words still owed.
    logic             in_write;  // Inside a write's data phase.

    wire addr_cyc = bus.dev_valid && bus.dev_addr_cyc;
    // Only plain reads and writes exist; nothing else is ever issued.
    wire rd_start = addr_cyc && (bus.dev_cmd == CMD_READ);
    wire wr_start = addr_cyc && (bus.dev_cmd == CMD_WRITE);

    // Reads are answered one word per cycle, never beyond eight.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rd_left         <= '0;
            in_write        <= 1'b0;
            bus.agt_valid   <= 1'b0;
            bus.agt_ad_oe_n <= 1'b1;
            bus.agt_ad_o    <= '0;
            wr_valid_o      <= 1'b0;
            wr_addr_o       <= '0;
            wr_data_o       <= '0;
            rd_req_o        <= 1'b0;
        end else if (clk_en_i) begin
            rd_req_o <= rd_start;
            if (rd_start) begin
                rd_left <= (bus.dev_len > CNT_W'(MAX_RD_WORDS)) ?
                           CNT_W'(MAX_RD_WORDS) : bus.dev_len;
            end else if (rd_left != '0) begin
                rd_left <= rd_left - CNT_W'(1);
            end
            bus.agt_valid   <= !rd_start && (rd_left != '0);
            bus.agt_ad_oe_n <= !(!rd_start && (rd_left != '0));
            bus.agt_ad_o    <= rd_data_i;
            if (wr_start) begin
                in_write  <= 1'b1;
                wr_addr_o <= bus.sys_addr_data_bus;
            end else if (rd_start) begin
                in_write <= 1'b0;
            end
            // Data words are taken whenever marked, whatever the spacing.
            wr_valid_o <= in_write && bus.dev_valid && !bus.dev_addr_cyc;
            wr_data_o  <= bus.sys_addr_data_bus;
        end
    end

endmodule : csbi_agent

// [csbi_bench.sv]
module csbi_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import csbi_pkg::*;
    // -----------
    // Stimulus and model state
    // -----------
    logic             core_clk_i = 1'b0;
    logic             srst_i     = 1'b1;
    logic             pat_sel = 0, rp_sel = 0, req_valid = 0, req_write = 0;
    logic             req_icache = 0, req_block = 0, soft_req = 0;
    logic [BUS_W-1:0] req_addr = '0, wr_data = '0, rd_src = '0, d = '0;
    logic             req_ready, rd_valid, rd_ovr, par_err, soft_rst, ovr2, a_wr_valid, wr_take, take_q;
    logic [BUS_W-1:0] rd_data, a_wr_addr, a_wr_data;
    logic [BUS_W:0]   wq[$], e;   // Expected write words; top bit marks a first word.
    logic [BUS_W-1:0] rq[$], aq[$], waq[$];
    int               at[$];      // Cycle numbers of address cycles.
    int               err_count = 0, n_checks = 0, cyc = 0, lastw = 0, gap = 1;
    int               extra = 0, r2 = 0;
    csbi_if bus ();
    csbi_if bus2 ();
    csbi_device i_csbi_device (.core_clk_i, .srst_i, .clk_en_i(1'b1),
        .write_pattern_select_i(pat_sel), .reduced_power_bit_i(rp_sel), .req_valid_i(req_valid),
        .req_write_i(req_write), .req_icache_i(req_icache), .req_block_i(req_block),
        .req_addr_i(req_addr), .wr_data_i(wr_data), .req_ready_o(req_ready), .wr_data_take_o(wr_take),
        .rd_valid_o(rd_valid), .rd_data_o(rd_data), .rd_overrun_o(rd_ovr),
        .parity_err_o(par_err), .soft_reset_o(soft_rst), .bus(bus));
    // Second device faces a bench driver that can overrun the read stream.
    csbi_device i_csbi_device_b (.core_clk_i, .srst_i, .clk_en_i(1'b1),
        .write_pattern_select_i(pat_sel), .reduced_power_bit_i(rp_sel), .req_valid_i(req_valid),
        .req_write_i(req_write), .req_icache_i(req_icache), .req_block_i(req_block),
        .req_addr_i(req_addr), .wr_data_i(wr_data), .req_ready_o(), .wr_data_take_o(),
        .rd_valid_o(), .rd_data_o(), .rd_overrun_o(ovr2), .parity_err_o(), .soft_reset_o(),
        .bus(bus2));
    csbi_agent i_csbi_agent (.core_clk_i, .srst_i, .clk_en_i(1'b1), .soft_rst_req_i(soft_req),
        .rd_data_i(rd_src), .wr_valid_o(a_wr_valid), .wr_addr_o(a_wr_addr),
        .wr_data_o(a_wr_data), .rd_req_o(), .bus(bus));
    csbi_monitor i_csbi_monitor (.core_clk_i, .srst_i, .dev_ad_oe_n(bus.dev_ad_oe_n),
        .agt_ad_oe_n(bus.agt_ad_oe_n), .dev_valid(bus.dev_valid),
        .dev_addr_cyc(bus.dev_addr_cyc), .dev_cmd(bus.dev_cmd), .dev_len(bus.dev_len),
        .agt_valid(bus.agt_valid), .bus_timing_clock(bus.bus_timing_clock),
        .system_sync_clock(bus.system_sync_clock), .rst_req(bus.rst_req));
    initial forever #10 core_clk_i = ~core_clk_i;
    // Far side of the second link: returns the asked length plus extra words.
    always @(posedge core_clk_i) begin
        if (srst_i)
            r2 <= 0;
        else if (bus2.dev_valid === 1'b1 && bus2.dev_addr_cyc === 1'b1 && bus2.dev_cmd === CMD_READ)
            r2 <= int'(bus2.dev_len) + extra;
        else if (r2 > 0)
            r2 <= r2 - 1;
        bus2.agt_valid   <= (r2 > 0);
        bus2.agt_ad_oe_n <= !(r2 > 0);
        bus2.agt_ad_o    <= $urandom; // Never a stale word on the lines.
        bus2.rst_req     <= 1'b0;
    end
    // -----------
    // Tasks
    // -----------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    // Mode pins are only sampled while reset is high, so they move with it.
    task automatic do_reset(input logic dxx, input logic rp);
        srst_i  <= 1'b1;
        pat_sel <= dxx;
        rp_sel  <= rp;
        repeat (16) @(posedge core_clk_i);
        srst_i  <= 1'b0;
        repeat (2) @(posedge core_clk_i);
    endtask : do_reset
    // Holds the request until the edge that sees ready, then returns.
    task automatic issue(input logic w, input logic ic, input logic blk, input logic newd);
        int n;
        int k;
        logic [BUS_W-1:0] a;
        n = !blk ? 1 : (ic ? ICACHE_WORDS : DCACHE_WORDS);
        a = $urandom;
        if (newd)
            d = $urandom;
        req_valid  <= 1'b1;
        req_write  <= w;
        req_icache <= ic;
        req_block  <= blk;
        req_addr   <= a;
        wr_data    <= d;
        rd_src     <= d;
        aq.push_back(a);
        if (w)
            waq.push_back(a);
        for (int i = 0; i < n; i++) begin
            if (w)
                wq.push_back({i == 0, d});
            else
                rq.push_back(d);
        end
        k = 0;
        do begin
            @(posedge core_clk_i);
            k++;
        end while (req_ready !== 1'b1 && k < 100);
    endtask : issue
    task automatic drain();
        int k;
        req_valid <= 1'b0;
        k = 0;
        while (wq.size() + rq.size() + aq.size() != 0 && k < 500) begin
            @(posedge core_clk_i);
            k++;
        end
        repeat (4) @(posedge core_clk_i);
        check("left", 0, 32'(wq.size() + rq.size() + aq.size()));
    endtask : drain
    task automatic half_period(output int n);
        logic c;
        c = bus.bus_timing_clock;
        n = 0;
        while (bus.bus_timing_clock === c && n < 50) begin
            @(posedge core_clk_i);
            n++;
        end
        c = bus.bus_timing_clock;
        n = 0;
        while (bus.bus_timing_clock === c && n < 50) begin
            @(posedge core_clk_i);
            n++;
        end
    endtask : half_period
    // Model compare at every address cycle and every returned word.
    always @(posedge core_clk_i) begin
        cyc++;
        if (bus.dev_valid === 1'b1 && bus.dev_addr_cyc === 1'b1) begin
            at.push_back(cyc);
            check("addr", aq.pop_front(), bus.sys_addr_data_bus);
        end
        if (a_wr_valid === 1'b1) begin
            e = wq.pop_front();
            check("wdata", e[31:0], a_wr_data);
            check("take", 1, 32'(take_q));
            if (e[32])
                check("waddr", waq.pop_front(), a_wr_addr);
            else
                check("gap", 32'(gap), 32'(cyc - lastw));
            lastw = cyc;
        end
        if (rd_valid === 1'b1)
            check("rdata", rq.pop_front(), rd_data);
        take_q = wr_take; // Device marks a word one cycle before the agent reports it.
    end
    initial begin
        repeat (20000) @(posedge core_clk_i);
        err_count++;
        report_and_stop();
    end
    initial begin
        int n;
        void'($urandom(32'h4F0F8547));
        do_reset(1'b0, 1'b0);
        check("ready", 1, req_ready);
        check("parity", 0, par_err);
        half_period(n);
        check("half", CLK_DIV_NORM, 32'(n));
        for (int k = 0; k < 6; k++) begin
            issue(k < 3, k % 3 == 2, k % 3 != 0, 1'b1);
            drain();
        end
        check("ovr_b", 0, ovr2);
        at.delete();
        issue(1'b1, 1'b0, 1'b0, 1'b1);
        issue(1'b1, 1'b0, 1'b0, 1'b0);
        drain();
        check("adad", 2, 32'(at[1] - at[0]));
        extra = 1;
        issue(1'b0, 1'b0, 1'b0, 1'b1);
        drain();
        check("ovr_b", 1, ovr2);
        check("ovr", 0, rd_ovr);
        extra = 0;
        soft_req <= 1'b1;
        @(posedge core_clk_i);
        soft_req <= 1'b0;
        n = 0;
        while (soft_rst !== 1'b1 && n < 200) begin
            @(posedge core_clk_i);
            n++;
        end
        check("soft", 1, soft_rst);
        do_reset(1'b1, 1'b0);
        gap = 1 + PAT_GAP_IDLE;
        issue(1'b1, 1'b1, 1'b1, 1'b1);
        drain();
        do_reset(1'b0, 1'b1);
        gap = 1;
        half_period(n);
        check("half", CLK_DIV_LOW, 32'(n));
        issue(1'b0, 1'b1, 1'b1, 1'b1);
        drain();
        report_and_stop();
    end
endmodule : csbi_bench

// [csbi_device.sv]
//Behaviour
// - 32-bit multiplexed address/data bus, no parity.
// - Two write patterns: D or Dxx.
// - D mode: requests back to back, no idle.
// - Accept reads one word/cycle, max eight.
// - Line transfers: eight instruction, four data.
// - One timing clock for send and receive.
// - Reduced power divides both clocks by four.
// - Agent holds soft reset sixteen clocks minimum.
// - Cold reset level held constant throughout.
// - Modes taken from pins at initialization.
// - Agent issues no coherence/secondary-cache transactions.
// - Never raise a cache parity error.
module csbi_device (
    // Clock, reset and enable
    input  wire logic                       core_clk_i,
    input  wire logic                       srst_i,
    input  wire logic                       clk_en_i,
    // Mode pins sampled at initialization
    input  wire logic                       write_pattern_select_i,
    input  wire logic                       reduced_power_bit_i,
    // User request port
    input  wire logic                       req_valid_i,
    input  wire logic                       req_write_i,
    input  wire logic                       req_icache_i,
    input  wire logic                       req_block_i,
    input  wire logic [csbi_pkg::BUS_W-1:0] req_addr_i,
    input  wire logic [csbi_pkg::BUS_W-1:0] wr_data_i,
    output logic                            req_ready_o,
    output logic                            wr_data_take_o,
    // User read return and status
    output logic                            rd_valid_o,
    output logic [csbi_pkg::BUS_W-1:0]      rd_data_o,
    output logic                            rd_overrun_o,
    output logic                            parity_err_o,
    output logic                            soft_reset_o,
    // Link to agent
    csbi_if.dev                             bus
);
    import csbi_pkg::*;

    //------------------------------------------------------------------
    // Mode capture
    //------------------------------------------------------------------
    logic pat_gap;      // Captured Dxx selection.
    logic low_pwr;      // Captured reduced-power selection.

    // Modes are caught on the clock while reset is held, so they stay
    // stable for the whole run and never follow a pin mid-transfer.
    always_ff @(posedge core_clk_i) begin
        if (clk_en_i && srst_i) begin
            pat_gap <= write_pattern_select_i;
            low_pwr <= reduced_power_bit_i;
        end
    end

    //------------------------------------------------------------------
    // Reset input synchroniser and soft reset length check
    //------------------------------------------------------------------
    logic       rst_s1;     // First stage, read only by the second.
    logic       rst_s2;     // Second stage.
    logic       rst_s3;     // Third stage.
    logic       rst_lvl;    // Filtered level; moves only when stages two and three agree.
    logic [4:0] rst_len;    // Cycles the agreed reset level has lasted.

    // The agent reset is a pin: three stages, agreed by stages two and three.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
            rst_s3 <= 1'b0;
            rst_lvl <= 1'b0;
        end else if (clk_en_i) begin
            rst_s1 <= bus.rst_req;
            rst_s2 <= rst_s1;
            rst_s3 <= rst_s2;
            if (rst_s2 == rst_s3) begin
                rst_lvl <= rst_s3;
            end
        end
    end

    // The filtered level keeps the full pulse length, so sixteen in is sixteen counted.

    // A pulse shorter than the least length is ignored as a glitch.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rst_len      <= 5'h00;
            soft_reset_o <= 1'b0;
        end else if (clk_en_i) begin
            rst_len      <= !rst_lvl ? 5'h00 :
                            (rst_len == SOFT_RST_CNT) ? rst_len : rst_len + 5'h01;
            soft_reset_o <= rst_lvl && (rst_len == SOFT_RST_CNT - 5'h01);
        end
    end

    //------------------------------------------------------------------
    // Clock outputs
    //------------------------------------------------------------------
    logic [2:0] clk_cnt;   // Half period counter.
    logic       clk_lvl;   // Shared level of both clock outputs.

    wire [2:0] half_per = low_pwr ? CLK_DIV_LOW : CLK_DIV_NORM;

    // One divider drives both outputs, so send and receive share timing.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            clk_cnt <= 3'h0;
            clk_lvl <= 1'b0;
        end else if (clk_en_i) begin
            clk_cnt <= (clk_cnt + 3'h1 >= half_per) ? 3'h0 : clk_cnt + 3'h1;
            if (clk_cnt + 3'h1 >= half_per) begin
                clk_lvl <= !clk_lvl;
            end
        end
    end

    assign bus.bus_timing_clock  = clk_lvl;
    assign bus.system_sync_clock = clk_lvl;

    //------------------------------------------------------------------
    // Request sequencer
    //------------------------------------------------------------------
    typedef enum {CSBI_IDLE, CSBI_WDATA, CSBI_WGAP, CSBI_RWAIT} csbi_state_t;

    csbi_state_t      state;     // Sequencer state.
    logic [CNT_W-1:0] words;     // Write words still to move; whole length of a read.
    logic [1:0]       gap;       // Idle cycles left after a write word.
    logic [CNT_W-1:0] rd_cnt;    // Read words received so far.

    // Block length follows the cache that owns the line.
    wire [CNT_W-1:0] req_len = !req_block_i  ? CNT_W'(1) :
                               req_icache_i  ? CNT_W'(ICACHE_WORDS) :
                                               CNT_W'(DCACHE_WORDS);

    wire take_req  = req_valid_i && req_ready_o;
    wire last_word = (words == CNT_W'(1));
    wire wr_beat   = (state == CSBI_WDATA);
    wire agt_word  = (state == CSBI_RWAIT) && bus.agt_valid;

    // Ready in idle, and in D mode on the last write word so the next
    // address follows the data with no idle cycle between.
    wire next_ready = (state == CSBI_IDLE && !take_req) ||
                      (wr_beat && last_word && !pat_gap) ||
                      (state == CSBI_WGAP && gap == 2'h1 && last_word) ||
                      (agt_word && (rd_cnt + CNT_W'(1) == words));

    // Address cycle is driven in the cycle after acceptance, from registers.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state <= CSBI_IDLE;
            words <= '0;
            gap   <= 2'h0;
            rd_cnt <= '0;
        end else if (clk_en_i) begin
            unique case (state)
                CSBI_IDLE, CSBI_WDATA, CSBI_WGAP, CSBI_RWAIT: begin
                    if (take_req) begin
                        state  <= req_write_i ? CSBI_WDATA : CSBI_RWAIT;
                        words  <= req_len;
                        rd_cnt <= '0;
                    end else if (wr_beat) begin
                        // Each word gets the same pattern for the whole block.
                        if (pat_gap) begin
                            state <= CSBI_WGAP;
                            gap   <= PAT_GAP_IDLE;
                        end else if (last_word) begin
                            state <= CSBI_IDLE;
                        end else begin
                            words <= words - CNT_W'(1);
                        end
                    end else if (state == CSBI_WGAP) begin
                        gap <= gap - 2'h1;
                        if (gap == 2'h1) begin
                            state <= last_word ? CSBI_IDLE : CSBI_WDATA;
                            words <= last_word ? words : words - CNT_W'(1);
                        end
                    end else if (agt_word) begin
                        rd_cnt <= rd_cnt + CNT_W'(1);
                        if (rd_cnt + CNT_W'(1) == words) begin
                            state <= CSBI_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    //------------------------------------------------------------------
    // Registered outputs
    //------------------------------------------------------------------
    // All bus outputs are registered; parity is neither made nor checked.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            req_ready_o      <= 1'b0;
            wr_data_take_o   <= 1'b0;
            rd_valid_o       <= 1'b0;
            rd_data_o        <= '0;
            rd_overrun_o     <= 1'b0;
            parity_err_o     <= 1'b0;
            bus.dev_ad_o     <= '0;
            bus.dev_ad_oe_n  <= 1'b1;
            bus.dev_valid    <= 1'b0;
            bus.dev_addr_cyc <= 1'b0;
            bus.dev_cmd      <= CMD_READ;
            bus.dev_len      <= '0;
        end else if (clk_en_i) begin
            req_ready_o      <= next_ready;
            wr_data_take_o   <= wr_beat;
            parity_err_o     <= 1'b0;
            rd_valid_o       <= agt_word;
            rd_data_o        <= bus.sys_addr_data_bus;
            // A word arriving with no read open, or past the requested length, is dropped.
            if (bus.agt_valid && !agt_word) begin
                rd_overrun_o <= 1'b1;
            end
            bus.dev_valid    <= take_req || wr_beat;
            bus.dev_addr_cyc <= take_req;
            bus.dev_ad_oe_n  <= !(take_req || wr_beat);
            bus.dev_ad_o     <= take_req ? req_addr_i : wr_data_i;
            if (take_req) begin
                bus.dev_cmd <= req_write_i ? CMD_WRITE : CMD_READ;
                bus.dev_len <= req_len;
            end
        end
    end

endmodule : csbi_device

// [csbi_if.sv]
interface csbi_if;
    import csbi_pkg::*;

    logic [BUS_W-1:0] dev_ad_o;       // Device drive value of the bus.
    logic             dev_ad_oe_n;    // Low while the device drives the bus.
    logic [BUS_W-1:0] agt_ad_o;       // Agent drive value of the bus.
    logic             agt_ad_oe_n;    // Low while the agent drives the bus.
    logic             dev_valid;      // Device presents an address or a data word.
    logic             dev_addr_cyc;   // Device cycle is an address cycle.
    logic [1:0]       dev_cmd;        // Request kind in an address cycle.
    logic [CNT_W-1:0] dev_len;        // Words in the request (1, 4 or 8).
    logic             agt_valid;      // Agent returns a read data word.
    logic             bus_timing_clock;  // Single timing clock from the device.
    logic             system_sync_clock; // System clock output from the device.
    logic             rst_req;        // Reset input driven by the agent.

    // Resolved bus value; neither side drives means all ones.
    wire [BUS_W-1:0] sys_addr_data_bus = !dev_ad_oe_n ? dev_ad_o :
                                         !agt_ad_oe_n ? agt_ad_o : '1;

    modport dev (
        output dev_ad_o, dev_ad_oe_n, dev_valid, dev_addr_cyc, dev_cmd, dev_len,
        output bus_timing_clock, system_sync_clock,
        input  agt_ad_o, agt_ad_oe_n, agt_valid, rst_req, sys_addr_data_bus
    );

    modport agt (
        input  dev_ad_o, dev_ad_oe_n, dev_valid, dev_addr_cyc, dev_cmd, dev_len,
        input  bus_timing_clock, system_sync_clock, sys_addr_data_bus,
        output agt_ad_o, agt_ad_oe_n, agt_valid, rst_req
    );

endinterface : csbi_if

// [csbi_monitor.sv]
module csbi_monitor (
    // Clock and reset
    input wire logic                       core_clk_i,
    input wire logic                       srst_i,
    // Bus enables and qualifiers
    input wire logic                       dev_ad_oe_n,
    input wire logic                       agt_ad_oe_n,
    input wire logic                       dev_valid,
    input wire logic                       dev_addr_cyc,
    input wire logic [1:0]                 dev_cmd,
    input wire logic [csbi_pkg::CNT_W-1:0] dev_len,
    input wire logic                       agt_valid,
    // Clock outputs and reset line
    input wire logic                       bus_timing_clock,
    input wire logic                       system_sync_clock,
    input wire logic                       rst_req
);
    timeunit 1ns;
    timeprecision 1ps;
    import csbi_pkg::*;
    // -----------
    // Helper logic
    // -----------
    logic [4:0]       hi_cnt;  // Cycles in a row with the reset line high.
    logic [CNT_W-1:0] rd_left; // Read words the agent still owes.
    wire addr_cyc = dev_valid && dev_addr_cyc;            // Any address cycle.
    wire rd_addr  = addr_cyc && (dev_cmd == CMD_READ);    // Read address cycle.
    // Saturating length of the current reset pulse.
    always_ff @(posedge core_clk_i) begin
        if (srst_i || !rst_req)
            hi_cnt <= '0;
        else if (hi_cnt != 5'h1F)
            hi_cnt <= hi_cnt + 5'h01;
    end
    // Loaded by a read address, emptied by returned words.
    always_ff @(posedge core_clk_i) begin
        if (srst_i)
            rd_left <= '0;
        else if (rd_addr)
            rd_left <= dev_len;
        else if (agt_valid && rd_left != '0)
            rd_left <= rd_left - CNT_W'(1);
    end
    // -----------
    // Properties
    // -----------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    property p_one_driver; dev_ad_oe_n || agt_ad_oe_n; endproperty
    property p_addr_drive; addr_cyc |-> !dev_ad_oe_n && agt_ad_oe_n; endproperty
    property p_len; addr_cyc |-> dev_len inside {1, DCACHE_WORDS, ICACHE_WORDS}; endproperty
    property p_wr_data;
        addr_cyc && dev_cmd == CMD_WRITE |=> dev_valid && !dev_addr_cyc && !dev_ad_oe_n;
    endproperty
    property p_rd_count; agt_valid |-> rd_left != '0 && !agt_ad_oe_n; endproperty
    property p_clk_div;
        $changed(bus_timing_clock) |=> $changed(bus_timing_clock) or
            ($stable(bus_timing_clock)[*3] ##1 $changed(bus_timing_clock));
    endproperty
    property p_clk_pair; $changed(bus_timing_clock) == $changed(system_sync_clock); endproperty
    property p_rst_hold; $fell(rst_req) |-> hi_cnt >= SOFT_RST_CNT; endproperty
    // Reset line checked while the block itself is held in reset.
    property p_rst_const;
        disable iff (1'b0) srst_i && $past(srst_i) && $past(srst_i, 2) |-> $stable(rst_req);
    endproperty
    a_one_driver: assert property (p_one_driver) else $error("two drivers on bus");
    a_addr_drive: assert property (p_addr_drive) else $error("address not driven");
    a_len: assert property (p_len) else $error("illegal length");
    a_wr_data: assert property (p_wr_data) else $error("write data late");
    a_rd_count: assert property (p_rd_count) else $error("read stream too long");
    a_clk_div: assert property (p_clk_div) else $error("bad clock rate");
    a_clk_pair: assert property (p_clk_pair) else $error("clocks differ");
    a_rst_hold: assert property (p_rst_hold) else $error("reset pulse short");
    a_rst_const: assert property (p_rst_const) else $error("reset line moved");
    c_long_rd: cover property (rd_addr && dev_len == ICACHE_WORDS);
    c_adad: cover property (dev_valid && !dev_addr_cyc ##1 addr_cyc);
    c_soft: cover property ($fell(rst_req));
endmodule : csbi_monitor

// [csbi_pkg.sv]
package csbi_pkg;

    //------------------------------------------------------------------
    // Bus geometry and transfer sizes
    //------------------------------------------------------------------
    localparam int unsigned BUS_W       = 32;        // Multiplexed address/data width.
    localparam int unsigned ICACHE_WORDS = 8;        // Instruction line fill/write-back length.
    localparam int unsigned DCACHE_WORDS = 4;        // Data line fill/write-back length.
    localparam int unsigned MAX_RD_WORDS = 8;        // Longest read stream the device accepts.
    localparam int unsigned CNT_W        = 4;        // Width of word counters.

    //------------------------------------------------------------------
    // Write pattern and clock division
    //------------------------------------------------------------------
    localparam logic [1:0] PAT_GAP_IDLE  = 2'h2;     // Idle cycles after a word in Dxx mode.
    localparam logic [2:0] CLK_DIV_NORM  = 3'h1;     // Half period, in core cycles, normal.
    localparam logic [2:0] CLK_DIV_LOW   = 3'h4;     // Half period in reduced-power mode.

    //------------------------------------------------------------------
    // Reset timing
    //------------------------------------------------------------------
    localparam int unsigned SOFT_RST_MIN = 16;       // Least soft reset length in input clocks.
    localparam logic [4:0]  SOFT_RST_CNT = 5'h10;    // Same figure at counter width.

    //------------------------------------------------------------------
    // Command encodings carried on the command lines in address cycles
    //------------------------------------------------------------------
    localparam logic [1:0] CMD_READ      = 2'h0;     // Read request.
    localparam logic [1:0] CMD_WRITE     = 2'h1;     // Write request.

endpackage : csbi_pkg
